// [design/mgmt_pkg.sv]
package mgmt_pkg;

    typedef logic [7:0] byte_t;

    typedef enum logic [3:0] {
        ST_IDLE, ST_DEV, ST_ACK_DEV, ST_REG, ST_ACK_REG, ST_WR, ST_ACK_WR, ST_RD, ST_ACK_RD
    } slave_state_t;

    // ----------------------------------------------------------------
    // Two-wire bus
    // ----------------------------------------------------------------
    localparam logic [6:0] DEV_ADDR = 7'h50;
    localparam logic [3:0] BIT_COUNT_FULL = 4'h8;
    localparam logic [3:0] BIT_COUNT_FIRST = 4'h1;

    // ----------------------------------------------------------------
    // Memory map
    // ----------------------------------------------------------------
    localparam int NUM_MON = 5;
    localparam byte_t ADDR_MON_LAST = 8'h04;
    localparam byte_t ADDR_ALARM_HI = 8'h05;
    localparam byte_t ADDR_ALARM_LO = 8'h06;
    localparam byte_t ADDR_WARN_HI = 8'h07;
    localparam byte_t ADDR_WARN_LO = 8'h08;
    localparam byte_t ADDR_STATUS = 8'h09;
    localparam byte_t ADDR_RAM_BASE = 8'h10;
    localparam byte_t ADDR_RAM_LAST = 8'h1F;
    localparam int RAM_DEPTH = 16;
    localparam int RAM_IDX_W = 4;
    localparam byte_t RESET_BYTE = 8'h00;
    localparam int STATUS_LOS_BIT = 0;
    localparam int STATUS_TXDIS_BIT = 1;
    localparam int STATUS_INT_BIT = 2;

    // Factory limits, index 0 temperature, 1 bias, 2 tx power, 3 rx power, 4 supply.
    localparam logic [NUM_MON-1:0][7:0] ALARM_HI = {8'hF0, 8'hF0, 8'hF0, 8'hF0, 8'hF0};
    localparam logic [NUM_MON-1:0][7:0] WARN_HI = {8'hE0, 8'hE0, 8'hE0, 8'hE0, 8'hE0};
    localparam logic [NUM_MON-1:0][7:0] WARN_LO = {8'h20, 8'h20, 8'h20, 8'h20, 8'h20};
    localparam logic [NUM_MON-1:0][7:0] ALARM_LO = {8'h10, 8'h10, 8'h10, 8'h10, 8'h10};

    // ----------------------------------------------------------------
    // Pins and timing
    // ----------------------------------------------------------------
    localparam int PIN_COUNT = 6;
    localparam int PIN_SCL = 0;
    localparam int PIN_SDA = 1;
    localparam int PIN_DESEL = 2;
    localparam int PIN_TXDIS = 3;
    localparam int PIN_PDOWN = 4;
    localparam int PIN_SIGDET = 5;
    // Synchroniser reset: bus idle high, deselected, transmit disabled, no signal.
    localparam logic [PIN_COUNT-1:0] PIN_RESET = 6'h0F;
    localparam int unsigned CLK_FREQ_HZ = 100_000_000;
    localparam int unsigned TX_TOGGLE_TIME_MS = 100;
    localparam int unsigned TX_TOGGLE_CYCLES = TX_TOGGLE_TIME_MS * (CLK_FREQ_HZ / 1000);

endpackage

// [design/mgmt_if.sv]
`timescale 1ns/1ps
interface mgmt_if;
    mgmt_pkg::byte_t addr;
    mgmt_pkg::byte_t wdata;
    logic we;
    mgmt_pkg::byte_t rdata;

    modport slave (output addr, output wdata, output we, input rdata);
    modport mem (input addr, input wdata, input we, output rdata);
endinterface

// [design/two_wire_slave.sv]
`timescale 1ns/1ps
module two_wire_slave (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic clear_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_drive_o,
    mgmt_if.slave bus
);
    import mgmt_pkg::*;

    slave_state_t state;
    logic scl_q;
    logic sda_q;
    logic rw;
    logic we;
    logic [3:0] bit_cnt;
    byte_t shreg;
    byte_t ptr;

    // ----------------------------------------------------------------
    // Bus conditions
    // ----------------------------------------------------------------
    wire scl_rise = scl_i & ~scl_q;
    wire scl_fall = ~scl_i & scl_q;
    wire start_seen = scl_i & scl_q & sda_q & ~sda_i;
    wire stop_seen = scl_i & scl_q & ~sda_q & sda_i;
    wire byte_full = (bit_cnt == BIT_COUNT_FULL);
    wire addr_match = (shreg[7:1] == DEV_ADDR);
    wire shift_state = (state == ST_DEV) || (state == ST_REG) || (state == ST_WR);

    assign bus.addr = ptr;
    assign bus.wdata = shreg;
    assign bus.we = we;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state <= ST_IDLE;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            rw <= 1'b0;
            we <= 1'b0;
            bit_cnt <= '0;
            shreg <= RESET_BYTE;
            ptr <= RESET_BYTE;
            sda_drive_o <= 1'b0;
        end else begin
            scl_q <= scl_i;
            sda_q <= sda_i;
            we <= 1'b0;
            if (clear_i) begin
                state <= ST_IDLE;
                bit_cnt <= '0;
                sda_drive_o <= 1'b0;
            end else if (start_seen) begin
                state <= ST_DEV;
                bit_cnt <= '0;
                sda_drive_o <= 1'b0;
            end else if (stop_seen) begin
                state <= ST_IDLE;
                sda_drive_o <= 1'b0;
            end else if (scl_rise) begin
                if (state == ST_ACK_RD && sda_i) begin
                    state <= ST_IDLE;
                end else if (shift_state) begin
                    shreg <= {shreg[6:0], sda_i};
                    bit_cnt <= bit_cnt + 4'h1;
                end
            end else if (scl_fall) begin
                case (state)
                    ST_DEV: begin
                        if (byte_full) begin
                            rw <= shreg[0];
                            sda_drive_o <= addr_match;
                            state <= addr_match ? ST_ACK_DEV : ST_IDLE;
                        end
                    end
                    ST_REG: begin
                        if (byte_full) begin
                            ptr <= shreg;
                            sda_drive_o <= 1'b1;
                            state <= ST_ACK_REG;
                        end
                    end
                    ST_WR: begin
                        if (byte_full) begin
                            we <= 1'b1;
                            sda_drive_o <= 1'b1;
                            state <= ST_ACK_WR;
                        end
                    end
                    ST_ACK_DEV: begin
                        bit_cnt <= BIT_COUNT_FIRST;
                        if (rw) begin
                            shreg <= {bus.rdata[6:0], 1'b1};
                            sda_drive_o <= ~bus.rdata[7];
                            state <= ST_RD;
                        end else begin
                            bit_cnt <= '0;
                            sda_drive_o <= 1'b0;
                            state <= ST_REG;
                        end
                    end
                    ST_ACK_REG: begin
                        bit_cnt <= '0;
                        sda_drive_o <= 1'b0;
                        state <= ST_WR;
                    end
                    ST_ACK_WR: begin
                        bit_cnt <= '0;
                        ptr <= ptr + 8'h01;
                        sda_drive_o <= 1'b0;
                        state <= ST_WR;
                    end
                    ST_RD: begin
                        if (byte_full) begin
                            ptr <= ptr + 8'h01;
                            sda_drive_o <= 1'b0;
                            state <= ST_ACK_RD;
                        end else begin
                            sda_drive_o <= ~shreg[7];
                            shreg <= {shreg[6:0], 1'b1};
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                    end
                    ST_ACK_RD: begin
                        bit_cnt <= BIT_COUNT_FIRST;
                        shreg <= {bus.rdata[6:0], 1'b1};
                        sda_drive_o <= ~bus.rdata[7];
                        state <= ST_RD;
                    end
                    default: begin
                        state <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_drive_on_fall: assert property (@(posedge clk_i) disable iff (!rstn_i)
        $rose(sda_drive_o) |-> $past(scl_fall))
        else $error("SDA drive began outside an SCL falling edge.");

    a_nack_ends_read: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (state == ST_ACK_RD && scl_rise && sda_i && !clear_i && !start_seen && !stop_seen)
        |=> (state == ST_IDLE) ##1 !sda_drive_o)
        else $error("Read did not stop after master not-acknowledge.");

endmodule // two_wire_slave

// [design/optical_module_mgmt_interface.sv]
// Functional notes
// - Answer two-wire commands only while deselect is low.
// - Pull interrupt low whenever a readable important condition exists.
// - Transmit disable turns the laser source off.
// - Laser off within 100 ms of disable, on within 100 ms of release.
// - Module-absent output is held low.
// - Receiver loss of signal is reported on its own pin.
// - Loss-of-signal pin is low when signal present, high when lost.
// - Power-down high keeps the module in low-power standby.
// - Power-down falling edge resets everything, two-wire interface included; the slave address pointer is not reset.
// - Data is taken on SCL rising edge into unprotected memory only.
// - Read data on SDA changes on SCL falling edge.
// - SDA is two-way; start and stop are SDA changes while SCL high.
// - Memory is 8-bit words, single or sequential with address increment.
// - Random and sequential access from address zero to the top.
// - Live temperature, bias, tx power, rx power, supply readings are readable.
// - Alarm and warning flags set when a reading leaves its limits.
`timescale 1ns/1ps
module optical_module_mgmt_interface #(
    parameter int unsigned TX_TOGGLE_LIMIT = mgmt_pkg::TX_TOGGLE_CYCLES
) (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic deselect_i,
    input wire logic transmit_disable_i,
    input wire logic power_down_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic signal_detect_i,
    input wire mgmt_pkg::byte_t mon_temperature_i,
    input wire mgmt_pkg::byte_t mon_bias_i,
    input wire mgmt_pkg::byte_t mon_tx_power_i,
    input wire mgmt_pkg::byte_t mon_rx_power_i,
    input wire mgmt_pkg::byte_t mon_supply_i,
    output logic sda_o,
    output logic sda_oe_o,
    output logic interrupt_n_o,
    output logic module_absent_o,
    output logic receive_signal_lost_o,
    output logic laser_enable_o,
    output logic standby_o
);
    import mgmt_pkg::*;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [PIN_COUNT-1:0] pin_meta;
    logic [PIN_COUNT-1:0] pin_sync;
    logic pd_prev;

    wire [PIN_COUNT-1:0] pin_raw = {signal_detect_i, power_down_i, transmit_disable_i,
                                    deselect_i, sda_i, scl_i};

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pin_meta <= PIN_RESET;
            pin_sync <= PIN_RESET;
            pd_prev <= 1'b0;
        end else begin
            pin_meta <= pin_raw;
            pin_sync <= pin_meta;
            pd_prev <= pin_sync[PIN_PDOWN];
        end
    end

    wire scl_s = pin_sync[PIN_SCL];
    wire sda_s = pin_sync[PIN_SDA];
    wire deselect_s = pin_sync[PIN_DESEL];
    wire transmit_disable_s = pin_sync[PIN_TXDIS];
    wire pd_s = pin_sync[PIN_PDOWN];
    wire sigdet_s = pin_sync[PIN_SIGDET];

    // A falling edge of power-down clears the flags, user memory and slave state, but keeps the slave address pointer.
    wire soft_clear = pd_prev & ~pd_s;
    wire slave_clear = deselect_s | pd_s | soft_clear;

    // ----------------------------------------------------------------
    // Two-wire slave
    // ----------------------------------------------------------------
    mgmt_if mem_bus ();

    two_wire_slave u_slave (
        .clk_i(clk_sys_i),
        .rstn_i(rstn_i),
        .clear_i(slave_clear),
        .scl_i(scl_s),
        .sda_i(sda_s),
        .sda_drive_o(sda_oe_o),
        .bus(mem_bus.slave)
    );

    // ----------------------------------------------------------------
    // Monitor readings and limit flags
    // ----------------------------------------------------------------
    byte_t mon_value [NUM_MON];
    logic [NUM_MON-1:0] alarm_hi;
    logic [NUM_MON-1:0] alarm_lo;
    logic [NUM_MON-1:0] warn_hi;
    logic [NUM_MON-1:0] warn_lo;
    logic [NUM_MON-1:0] next_alarm_hi;
    logic [NUM_MON-1:0] next_alarm_lo;
    logic [NUM_MON-1:0] next_warn_hi;
    logic [NUM_MON-1:0] next_warn_lo;

    assign mon_value[0] = mon_temperature_i;
    assign mon_value[1] = mon_bias_i;
    assign mon_value[2] = mon_tx_power_i;
    assign mon_value[3] = mon_rx_power_i;
    assign mon_value[4] = mon_supply_i;

    for (genvar i = 0; i < NUM_MON; i++) begin : g_limit
        assign next_alarm_hi[i] = mon_value[i] > ALARM_HI[i];
        assign next_alarm_lo[i] = mon_value[i] < ALARM_LO[i];
        assign next_warn_hi[i] = mon_value[i] > WARN_HI[i];
        assign next_warn_lo[i] = mon_value[i] < WARN_LO[i];
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            alarm_hi <= '0;
            alarm_lo <= '0;
            warn_hi <= '0;
            warn_lo <= '0;
        end else if (soft_clear) begin
            alarm_hi <= '0;
            alarm_lo <= '0;
            warn_hi <= '0;
            warn_lo <= '0;
        end else begin
            alarm_hi <= next_alarm_hi;
            alarm_lo <= next_alarm_lo;
            warn_hi <= next_warn_hi;
            warn_lo <= next_warn_lo;
        end
    end

    wire flag_any = |{alarm_hi, alarm_lo, warn_hi, warn_lo};
    wire attention = flag_any | ~sigdet_s;

    // ----------------------------------------------------------------
    // User memory and read mux
    // ----------------------------------------------------------------
    logic [RAM_DEPTH-1:0][7:0] user_ram;

    wire ram_hit = (mem_bus.addr >= ADDR_RAM_BASE) && (mem_bus.addr <= ADDR_RAM_LAST);
    wire mon_hit = (mem_bus.addr <= ADDR_MON_LAST);
    wire [RAM_IDX_W-1:0] ram_idx = mem_bus.addr[RAM_IDX_W-1:0];
    wire [2:0] mon_idx = mem_bus.addr[2:0];
    wire ram_write = mem_bus.we & ram_hit;

    byte_t status_byte;
    assign status_byte = {5'h00, ~interrupt_n_o, transmit_disable_s, ~sigdet_s};

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            user_ram <= '0;
        end else if (soft_clear) begin
            user_ram <= '0;
        end else if (ram_write) begin
            user_ram[ram_idx] <= mem_bus.wdata;
        end
    end

    // Unmapped addresses read as zero so a sequential read can run to the top.
    assign mem_bus.rdata = ram_hit ? user_ram[ram_idx] :
                           mon_hit ? mon_value[mon_idx] :
                           (mem_bus.addr == ADDR_ALARM_HI) ? {3'h0, alarm_hi} :
                           (mem_bus.addr == ADDR_ALARM_LO) ? {3'h0, alarm_lo} :
                           (mem_bus.addr == ADDR_WARN_HI) ? {3'h0, warn_hi} :
                           (mem_bus.addr == ADDR_WARN_LO) ? {3'h0, warn_lo} :
                           (mem_bus.addr == ADDR_STATUS) ? status_byte :
                           RESET_BYTE;

    // ----------------------------------------------------------------
    // Pin outputs
    // ----------------------------------------------------------------
    wire next_laser = ~transmit_disable_s & ~pd_s;

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            laser_enable_o <= 1'b0;
            standby_o <= 1'b0;
            interrupt_n_o <= 1'b1;
            receive_signal_lost_o <= 1'b1;
            module_absent_o <= 1'b0;
            sda_o <= 1'b0;
        end else begin
            laser_enable_o <= next_laser;
            standby_o <= pd_s;
            interrupt_n_o <= ~attention;
            receive_signal_lost_o <= ~sigdet_s;
            module_absent_o <= 1'b0;
            sda_o <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    int unsigned tx_lag;

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tx_lag <= 0;
        end else if (laser_enable_o != next_laser) begin
            tx_lag <= tx_lag + 1;
        end else begin
            tx_lag <= 0;
        end
    end

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rstn_i);

    a_deselect_quiet: assert property (deselect_s [*2] |-> !sda_oe_o)
        else $error("SDA driven while module deselected.");

    a_irq_follows: assert property (attention |=> !interrupt_n_o)
        else $error("Interrupt not asserted for pending condition.");

    a_laser_off: assert property (transmit_disable_s |=> !laser_enable_o)
        else $error("Laser enabled while transmit disable asserted.");

    a_tx_lag_bound: assert property (tx_lag < TX_TOGGLE_LIMIT)
        else $error("Laser did not follow transmit disable in time.");

    a_absent_low: assert property (!module_absent_o)
        else $error("Module-absent output not low.");

    a_los_level: assert property (sigdet_s ##1 sigdet_s |-> !receive_signal_lost_o)
        else $error("Loss of signal high while signal present.");

    a_los_raise: assert property (!sigdet_s |=> receive_signal_lost_o)
        else $error("Loss of signal not reported.");

    a_standby_hold: assert property (pd_s |=> standby_o && !laser_enable_o)
        else $error("Standby not held during power-down.");

    a_pd_reset: assert property (soft_clear |=> (user_ram == '0) && !sda_oe_o)
        else $error("Power-down release did not reset the module.");

    a_protect_write: assert property (mem_bus.we && !ram_hit && !soft_clear
        |=> $stable(user_ram))
        else $error("Write reached a protected location.");

    a_write_lands: assert property (ram_write && !soft_clear
        |=> user_ram[$past(ram_idx)] == $past(mem_bus.wdata))
        else $error("Write data not stored in user memory.");

endmodule // optical_module_mgmt_interface

// [dv/host_two_wire.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Host side of the two-wire bus
// ----------------------------------------------------------------
// The host alone makes SCL and only ever pulls SDA low; the pull-up gives the high level.
module host_two_wire (
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_low_o
);
    logic odd;

    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
        odd = 1'b0;
    end

    task automatic wait_n(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    // Low phase of 6 or 7 cycles and high phase of 6 give a 125 ns average period.
    task automatic clock_bit(input logic b, output logic seen);
        sda_low_o = ~b;
        wait_n(3 + int'(odd));
        odd = ~odd;
        scl_o = 1'b1;
        wait_n(6);
        seen = sda_i;
        scl_o = 1'b0;
        wait_n(3);
    endtask

    // Serves as start and repeated start: SDA falls while SCL is high.
    task automatic start();
        sda_low_o = 1'b0;
        wait_n(3);
        scl_o = 1'b1;
        wait_n(6);
        sda_low_o = 1'b1;
        wait_n(6);
        scl_o = 1'b0;
        wait_n(3);
    endtask

    task automatic stop();
        sda_low_o = 1'b1;
        wait_n(3);
        scl_o = 1'b1;
        wait_n(6);
        sda_low_o = 1'b0;
        wait_n(6);
    endtask

    task automatic write_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(b[i], s);
        end
        clock_bit(1'b1, s);
        ack = ~s;
    endtask

    task automatic read_byte(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(1'b1, b[i]);
        end
        clock_bit(last, s);
    endtask
endmodule // host_two_wire

// [dv/test_optical_module_mgmt_interface.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errors++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_optical_module_mgmt_interface;
    import mgmt_pkg::*;
    logic clk, rstn, desel, txdis, pdown, sig_det, scl, sda_low, sda_wire;
    logic sda_val, sda_oe, int_n, absent, los, laser, standby;
    byte_t mon [5];
    byte_t r0, r1;
    int errors = 0;
    int comparisons = 0;
    int cycles = 0;

    assign sda_wire = ~(sda_low | (sda_oe & ~sda_val));

    optical_module_mgmt_interface #(.TX_TOGGLE_LIMIT(16)) optical_module_mgmt_interface_i (
        .clk_sys_i(clk), .rstn_i(rstn), .deselect_i(desel), .transmit_disable_i(txdis),
        .power_down_i(pdown), .scl_i(scl), .sda_i(sda_wire), .signal_detect_i(sig_det),
        .mon_temperature_i(mon[0]), .mon_bias_i(mon[1]), .mon_tx_power_i(mon[2]),
        .mon_rx_power_i(mon[3]), .mon_supply_i(mon[4]), .sda_o(sda_val), .sda_oe_o(sda_oe),
        .interrupt_n_o(int_n), .module_absent_o(absent), .receive_signal_lost_o(los),
        .laser_enable_o(laser), .standby_o(standby));

    host_two_wire host_two_wire_i (.clk_i(clk), .sda_i(sda_wire), .scl_o(scl),
        .sda_low_o(sda_low));

    // ----------------------------------------------------------------
    // Clock, timeout and verdict
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            errors++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        if (errors == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Bus helpers
    // ----------------------------------------------------------------
    task automatic wr(input byte_t a, input byte_t d0, input byte_t d1, input logic two);
        logic k;
        host_two_wire_i.start();
        host_two_wire_i.write_byte({DEV_ADDR, 1'b0}, k);
        `CHK(k, 1'b1)
        host_two_wire_i.write_byte(a, k);
        host_two_wire_i.write_byte(d0, k);
        `CHK(k, 1'b1)
        if (two) begin
            host_two_wire_i.write_byte(d1, k);
        end
        host_two_wire_i.stop();
    endtask

    // Random read of two bytes in sequence.
    task automatic rd2(input byte_t a, output byte_t q0, output byte_t q1);
        logic k;
        host_two_wire_i.start();
        host_two_wire_i.write_byte({DEV_ADDR, 1'b0}, k);
        host_two_wire_i.write_byte(a, k);
        host_two_wire_i.start();
        host_two_wire_i.write_byte({DEV_ADDR, 1'b1}, k);
        `CHK(k, 1'b1)
        host_two_wire_i.read_byte(1'b0, q0);
        host_two_wire_i.read_byte(1'b1, q1);
        host_two_wire_i.stop();
    endtask

    task automatic refused_address(input byte_t dev);
        logic k;
        host_two_wire_i.start();
        host_two_wire_i.write_byte(dev, k);
        `CHK(k, 1'b0)
        `CHK(sda_oe, 1'b0)
        host_two_wire_i.stop();
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_pins();
        `CHK(absent, 1'b0)
        `CHK(sda_val, 1'b0)
        sig_det = 1'b0;
        host_two_wire_i.wait_n(6);
        `CHK(los, 1'b1)
        `CHK(int_n, 1'b0)
        sig_det = 1'b1;
        host_two_wire_i.wait_n(6);
        `CHK(los, 1'b0)
        `CHK(int_n, 1'b1)
    endtask

    task automatic t_laser();
        `CHK(laser, 1'b1)
        txdis = 1'b1;
        host_two_wire_i.wait_n(6);
        `CHK(laser, 1'b0)
        txdis = 1'b0;
        host_two_wire_i.wait_n(6);
        `CHK(laser, 1'b1)
    endtask

    task automatic t_reset();
        txdis = 1'b1;
        host_two_wire_i.wait_n(6);
        rstn = 1'b0;
        host_two_wire_i.wait_n(2);
        rstn = 1'b1;
        host_two_wire_i.wait_n(2);
        `CHK(laser, 1'b0)
        txdis = 1'b0;
        host_two_wire_i.wait_n(6);
        `CHK(laser, 1'b1)
        `CHK(los, 1'b0)
    endtask

    task automatic t_ram();
        wr(8'h1E, 8'hA5, 8'h5A, 1'b1);
        rd2(8'h1E, r0, r1);
        `CHK(r0, 8'hA5)
        `CHK(r1, 8'h5A)
        wr(ADDR_RAM_LAST, 8'hC3, 8'h77, 1'b1);
        rd2(ADDR_RAM_LAST, r0, r1);
        `CHK(r0, 8'hC3)
        `CHK(r1, RESET_BYTE)
    endtask

    task automatic t_readings();
        mon = '{8'h31, 8'h32, 8'h33, 8'h34, 8'h35};
        wr(8'h00, 8'hFF, 8'hFF, 1'b0);
        rd2(8'h00, r0, r1);
        `CHK(r0, 8'h31)
        `CHK(r1, 8'h32)
        rd2(8'h02, r0, r1);
        `CHK(r0, 8'h33)
        rd2(8'h03, r0, r1);
        `CHK(r0, 8'h34)
        `CHK(r1, 8'h35)
    endtask

    task automatic t_flags();
        mon = '{8'hF5, 8'hE5, 8'h18, 8'h08, 8'hF1};
        host_two_wire_i.wait_n(8);
        `CHK(int_n, 1'b0)
        rd2(ADDR_ALARM_HI, r0, r1);
        `CHK(r0, 8'h11)
        `CHK(r1, 8'h08)
        rd2(ADDR_WARN_HI, r0, r1);
        `CHK(r0, 8'h13)
        `CHK(r1, 8'h0C)
        rd2(ADDR_STATUS, r0, r1);
        `CHK(r0, 8'h04)
        `CHK(r1, RESET_BYTE)
        mon = '{8'h80, 8'h80, 8'h80, 8'h80, 8'h80};
        host_two_wire_i.wait_n(8);
        `CHK(int_n, 1'b1)
    endtask

    task automatic t_deselect();
        desel = 1'b1;
        host_two_wire_i.wait_n(4);
        refused_address({DEV_ADDR, 1'b0});
        desel = 1'b0;
        host_two_wire_i.wait_n(4);
        refused_address({DEV_ADDR ^ 7'h01, 1'b0});
    endtask

    task automatic t_power_down();
        wr(ADDR_RAM_BASE, 8'h66, 8'h00, 1'b0);
        rd2(ADDR_RAM_BASE, r0, r1);
        `CHK(r0, 8'h66)
        pdown = 1'b1;
        host_two_wire_i.wait_n(6);
        `CHK(standby, 1'b1)
        `CHK(laser, 1'b0)
        refused_address({DEV_ADDR, 1'b0});
        pdown = 1'b0;
        host_two_wire_i.wait_n(8);
        `CHK(standby, 1'b0)
        rd2(ADDR_RAM_BASE, r0, r1);
        `CHK(r0, RESET_BYTE)
    endtask

    initial begin
        rstn = 1'b0;
        desel = 1'b0;
        txdis = 1'b0;
        pdown = 1'b0;
        sig_det = 1'b1;
        for (int i = 0; i < 5; i++) begin
            mon[i] = 8'h80;
        end
        repeat (3) @(negedge clk);
        rstn = 1'b1;
        host_two_wire_i.wait_n(4);
        t_pins();
        t_laser();
        t_reset();
        t_ram();
        t_readings();
        t_flags();
        t_deselect();
        t_power_down();
        tally_and_finish();
    end
endmodule // test_optical_module_mgmt_interface
